//--- core/sdac_core.sv
/*
 * Serial input and update logic of an 8-bit voltage-output converter.
 * Assumes the host keeps the link clock slow enough for clk_i to see
 * each level; link pins are asynchronous and resynchronised here.
 */
// Function
// - data bit sampled into 16-bit shifter on each falling link-clock edge.
// - shifter accepts bits only while frame select is low.
// - on the 16th falling edge, received word loads the converter register.
// - frame select rising before edge 16 discards the partial word.
// - after reset the converter register holds the zero code.
// - converter register is an 8-bit unsigned code, all ones full scale.
module sdac_core #(
    parameter int unsigned FRAME_BITS = sdac_pkg::FRAME_BITS
) (
    // clock, reset, enable
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    input  wire logic                           en_i,
    // serial link from host
    input  wire logic                           frame_n_i,
    input  wire logic                           sclk_i,
    input  wire logic                           din_i,
    // converter outputs
    output      logic [sdac_pkg::CODE_BITS-1:0] analog_output_o,
    output      logic [1:0]                     pd_mode_o,
    output      logic                           update_o,
    output      logic                           abort_o
);

    // ------------------------------------------------------------------
    // local constants
    // ------------------------------------------------------------------
    localparam int unsigned CODE_END = sdac_pkg::CODE_LSB +
                                       sdac_pkg::CODE_BITS;
    localparam int unsigned PD_END   = sdac_pkg::PD_LSB +
                                       sdac_pkg::PD_BITS;
    localparam int unsigned CNT_SPAN = 2 ** sdac_pkg::CNT_BITS;
    localparam int unsigned LAST_BIT = int'(sdac_pkg::CNT_LAST);

    localparam logic [sdac_pkg::CNT_BITS-1:0] CNT_STEP = 5'h01;

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    // field positions are package constants, so only one frame
    // length can be served
    if (FRAME_BITS != sdac_pkg::FRAME_BITS) begin : g_bad_frame
        $error("frame length must match the word layout");
    end

    // the bit counter must reach the last bit of a frame
    if (CNT_SPAN < FRAME_BITS) begin : g_bad_count
        $error("bit counter too narrow for the frame length");
    end

    if (LAST_BIT != FRAME_BITS - 1) begin : g_bad_last
        $error("last-bit count must be one below the frame length");
    end

    // both fields must lie inside the word and must not overlap
    if (CODE_END > FRAME_BITS) begin : g_bad_code
        $error("code field runs past the end of the word");
    end

    if (PD_END > FRAME_BITS) begin : g_bad_pd
        $error("power-down field runs past the end of the word");
    end

    if (CODE_END > sdac_pkg::PD_LSB) begin : g_bad_overlap
        $error("code and power-down fields overlap");
    end

    // a one-bit word leaves no room for the shift path below
    if (FRAME_BITS < 2) begin : g_bad_short
        $error("frame must hold at least two bits");
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                           sclk_d;
        logic                           frame_d;
        logic                           active;
        logic [sdac_pkg::CNT_BITS-1:0]  count;
        logic [FRAME_BITS-1:0]          shift;
        logic [sdac_pkg::CODE_BITS-1:0] code;
        logic [1:0]                     pd_mode;
        logic                           update;
        logic                           abort;
    } sdac_core_st_t;

    sdac_core_st_t        st;
    sdac_core_st_t        next_st;
    sdac_pkg::sdac_pins_t pins_raw;
    sdac_pkg::sdac_pins_t pins;
    logic                 sclk_fall;
    logic                 frame_rise;
    logic [FRAME_BITS-1:0] word;
    logic [sdac_pkg::CODE_BITS-1:0] code_field;
    logic [sdac_pkg::PD_BITS-1:0]   pd_field;

    assign pins_raw = '{frame_n: frame_n_i, sclk: sclk_i, din: din_i};

    sdac_sync u_sync (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .en_i   (en_i),
        .pins_i (pins_raw),
        .pins_o (pins)
    );

    // ------------------------------------------------------------------
    // edge finding and frame tracking
    // ------------------------------------------------------------------
    assign sclk_fall  = st.sclk_d & ~pins.sclk;
    assign frame_rise = ~st.frame_d & pins.frame_n;
    assign word       = {st.shift[FRAME_BITS-2:0], pins.din};

    // ------------------------------------------------------------------
    // word fields
    // ------------------------------------------------------------------
    // decoded from the word as it will stand after the current shift,
    // so the last bit lands in the same cycle as the load
    assign code_field = word[sdac_pkg::CODE_LSB +: sdac_pkg::CODE_BITS];
    assign pd_field   = word[sdac_pkg::PD_LSB +: sdac_pkg::PD_BITS];

    // ------------------------------------------------------------------
    // frame sequencing
    // ------------------------------------------------------------------
    // latency: pin edge to output is two sync flops and the output register,
    // three clk_i cycles, as the edge flop adds none; the host must hold each link level for at
    // least three clk_i cycles, which caps the link well below 30 MHz

    always_comb begin
        next_st        = st;
        next_st.update = 1'b0;
        next_st.abort  = 1'b0;
        if (en_i) begin
            next_st.sclk_d  = pins.sclk;
            next_st.frame_d = pins.frame_n;
            if (pins.frame_n) begin
                // partial word dropped, register left alone
                next_st.active = 1'b0;
                next_st.count  = sdac_pkg::CNT_ZERO;
                next_st.abort  = frame_rise & st.active &
                                 (st.count != sdac_pkg::CNT_ZERO);
            end else if (st.active && sclk_fall) begin
                next_st.shift = word;
                if (st.count == sdac_pkg::CNT_LAST) begin
                    // later edges in the same frame are ignored until
                    // frame select goes high again
                    next_st.active  = 1'b0;
                    next_st.count   = sdac_pkg::CNT_ZERO;
                    next_st.code    = code_field;
                    next_st.pd_mode = pd_field;
                    next_st.update  = 1'b1;
                end else begin
                    next_st.count = st.count + CNT_STEP;
                end
            end else if (st.frame_d) begin
                // frame just opened
                next_st.active = 1'b1;
                next_st.count  = sdac_pkg::CNT_ZERO;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st         <= '0;
            st.sclk_d  <= 1'b1;
            st.frame_d <= 1'b1;
            st.code    <= sdac_pkg::CODE_RESET;
            st.pd_mode <= sdac_pkg::SDAC_PD_NORMAL;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign analog_output_o = st.code;
    assign pd_mode_o       = st.pd_mode;
    assign update_o        = st.update;
    assign abort_o         = st.abort;

endmodule

//--- core/sdac_pkg.sv
/*
 * Shared constants and carrier types for the serial converter input logic.
 * Assumes a single system clock domain; link pins are sampled by the core.
 */
package sdac_pkg;

    // ------------------------------------------------------------------
    // word layout
    // ------------------------------------------------------------------
    localparam int unsigned FRAME_BITS = 16;
    localparam int unsigned CODE_BITS  = 8;
    localparam int unsigned CNT_BITS   = 5;
    // code field sits in bits 11:4, power-down field in bits 13:12
    localparam int unsigned CODE_LSB   = 4;
    localparam int unsigned PD_LSB     = 12;
    localparam int unsigned PD_BITS    = 2;

    localparam logic [CODE_BITS-1:0] CODE_RESET = 8'h00;
    localparam logic [CNT_BITS-1:0]  CNT_LAST   = 5'h0F;
    localparam logic [CNT_BITS-1:0]  CNT_ZERO   = 5'h00;

    // ------------------------------------------------------------------
    // power-down modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SDAC_PD_NORMAL = 2'b00,
        SDAC_PD_1K     = 2'b01,
        SDAC_PD_100K   = 2'b10,
        SDAC_PD_HIZ    = 2'b11
    } sdac_pd_t;

    // ------------------------------------------------------------------
    // link timing
    // ------------------------------------------------------------------
    localparam int unsigned SCLK_MAX_MHZ = 30;

    // sampled serial pins
    typedef struct packed {
        logic frame_n;
        logic sclk;
        logic din;
    } sdac_pins_t;

    // converter output state
    typedef struct packed {
        logic [CODE_BITS-1:0] code;
        sdac_pd_t             pd_mode;
        logic                 update;
    } sdac_out_t;

endpackage

//--- core/sdac_sync.sv
/*
 * Two-stage synchroniser for the serial pins, a bundle at a time.
 * Assumes inputs are asynchronous to clk_i; stage one feeds stage two only.
 */
module sdac_sync (
    // clock, reset and enable
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               en_i,
    // pins
    input  wire sdac_pkg::sdac_pins_t pins_i,
    output      sdac_pkg::sdac_pins_t pins_o
);

    typedef struct packed {
        sdac_pkg::sdac_pins_t meta;
        sdac_pkg::sdac_pins_t sync;
    } sdac_sync_st_t;

    sdac_sync_st_t st;
    sdac_sync_st_t next_st;

    // idle level: frame high, clock high
    localparam sdac_pkg::sdac_pins_t IDLE = 3'h6;

    always_comb begin
        next_st = st;
        if (en_i) begin
            next_st.meta = pins_i;
            next_st.sync = st.meta;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= {IDLE, IDLE};
        end else begin
            st <= next_st;
        end
    end

    assign pins_o = st.sync;

endmodule

//--- verif/sdac_core_properties.sv
/* Port checker for sdac_core.
   Assumes it is bound to every sdac_core; one clock domain. */
module sdac_core_properties #(
    parameter int unsigned FRAME_BITS = 16
) (
    // clock and reset
    input wire logic       clk_i,
    input wire logic       rst_i,
    // link and converter
    input wire logic       frame_n_i,
    input wire logic       sclk_i,
    input wire logic [7:0] analog_output_o,
    input wire logic [1:0] pd_mode_o,
    input wire logic       update_o,
    input wire logic       abort_o
);
    logic [4:0] falls;
    logic       sclk_q;
    // raw pin falls; the frame hold covers the sync delay
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i) {falls, sclk_q} <= 6'h01;
        else begin
            sclk_q <= sclk_i;
            falls  <= frame_n_i ? 5'h00 : falls + 5'(sclk_q & ~sclk_i);
        end
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_reset_zero: assert property (disable iff (1'b0)
        rst_i |-> {analog_output_o, pd_mode_o} == 10'h000)
        else $error("output not zero in reset");
    a_word_length: assert property (
        update_o |-> falls == 5'(FRAME_BITS)) else $error("bad length");
    a_hold_code: assert property (
        !update_o |-> $stable(analog_output_o)) else $error("code moved");
    a_hold_mode: assert property (
        !update_o |-> $stable(pd_mode_o)) else $error("mode moved");
    a_update_pulse: assert property (
        update_o |=> !update_o) else $error("update too long");
    a_abort_pulse: assert property (
        abort_o |=> !abort_o) else $error("abort too long");
    a_abort_frame: assert property (
        abort_o |-> !update_o && $past(frame_n_i, 2)) else $error("abort");
    a_idle_quiet: assert property (
        frame_n_i [*3] |-> !update_o) else $error("update while idle");
endmodule
bind sdac_core sdac_core_properties #(.FRAME_BITS(FRAME_BITS)) i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .frame_n_i(frame_n_i), .sclk_i(sclk_i),
    .analog_output_o(analog_output_o), .pd_mode_o(pd_mode_o),
    .update_o(update_o), .abort_o(abort_o));

//--- verif/sdac_core_test.sv
/* Self-checking bench for sdac_core.
   Assumes sdac_host on the link and the bound checker. */
module sdac_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_i;
    logic       rst_i;
    logic       frame_n;
    logic       sclk;
    logic       din;
    logic [7:0] code;
    logic [1:0] pd_mode;
    logic       update;
    logic       abort;
    logic       en = 1'b1;
    int         mismatches = 0;
    int         cmp_count = 0;
    int         n_upd = 0;
    int         n_abt = 0;
    int         e_upd = 0;
    int         e_abt = 0;
    sdac_host i_host (.clk_i(clk_i), .frame_n_o(frame_n), .sclk_o(sclk),
        .din_o(din));
    sdac_core #(.FRAME_BITS(16)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .en_i(en), .frame_n_i(frame_n), .sclk_i(sclk), .din_i(din),
        .analog_output_o(code), .pd_mode_o(pd_mode), .update_o(update),
        .abort_o(abort));
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        n_upd += int'(update === 1'b1);
        n_abt += int'(abort === 1'b1);
    end
    function automatic logic [13:0] snap();
        return {code, pd_mode, 2'(n_upd), 2'(n_abt)};
    endfunction
    task automatic check(input logic [13:0] got, input logic [13:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic t_reset();
        check(snap(), 14'h0000);
        i_host.send(16'hCFFA, 16);
        e_upd++;
        check(snap(), {8'hFF, 2'h0, 2'(e_upd), 2'h0});
        @(posedge clk_i);
        #2 rst_i = 1'b1;
        @(posedge clk_i);
        #2;
        check(snap(), {10'h000, 2'(e_upd), 2'h0});
        #2 rst_i = 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic t_modes();
        logic [7:0] c [4] = '{8'h01, 8'h80, 8'h5A, 8'hFE};
        for (int m = 0; m < 4; m++) begin
            i_host.send({2'b11, 2'(m), c[m], 4'h5}, 16);
            e_upd++;
            check(snap(), {c[m], 2'(m), 2'(e_upd), 2'(e_abt)});
        end
    endtask
    task automatic t_abort();
        for (int k = 1; k < 16; k += 14) begin
            i_host.send(16'h0000, k);
            e_abt++;
            check(snap(), {8'hFE, 2'h3, 2'(e_upd), 2'(e_abt)});
        end
    endtask
    // a whole frame sent while frozen must leave no trace
    task automatic t_freeze();
        en = 1'b0;
        i_host.send(16'h3AAA, 16);
        en = 1'b1;
        i_host.tick(8);
        check(snap(), {8'hFE, 2'h3, 2'(e_upd), 2'(e_abt)});
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        rst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        #2 rst_i = 1'b0;
        repeat (4) @(posedge clk_i);
        t_reset();
        t_modes();
        t_abort();
        t_freeze();
        end_sim();
    end
endmodule

//--- verif/sdac_host.sv
/* Host model: frame select, link clock and data.
   Assumes clk_i is the 40 MHz bench clock. */
module sdac_host (
    // bench clock
    input  wire logic clk_i,
    // serial link
    output      logic frame_n_o,
    output      logic sclk_o,
    output      logic din_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {frame_n_o, sclk_o, din_o} = 3'b110;
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask
    // msb first; link clock idles high, still between frames
    task automatic send(input logic [15:0] w, input int n);
        tick(1);
        frame_n_o = 1'b0;
        tick(8);
        for (int i = 15; i > 15 - n; i--) begin
            din_o = w[i];
            tick(4); // 5 MHz link
            sclk_o = 1'b0;
            tick(4);
            sclk_o = 1'b1;
        end
        tick(8);
        {frame_n_o, din_o} = {1'b1, ~din_o}; // no stale bit once released
        tick(8);
    endtask
endmodule
